/* include/mms_regs.svh */
// register offsets, field positions, reset values and fixed addresses
`ifndef MMS_REGS_SVH
`define MMS_REGS_SVH
// apb byte offsets
`define MMS_OFF_CTRL 8'h00
`define MMS_OFF_STATUS 8'h04
`define MMS_OFF_PC 8'h08
`define MMS_OFF_STWORD 8'h0C
`define MMS_OFF_RADDR 8'h10
`define MMS_OFF_RDATA 8'h14
// control and status field positions
`define MMS_CTRL_MB 0
`define MMS_CTRL_RB 1
`define MMS_STAT_MB 4
`define MMS_STAT_RB 5
// program memory
`define MMS_ROM_TOP 12'hBFF
`define MMS_VEC_RESET 12'h000
`define MMS_VEC_EXT 12'h003
`define MMS_VEC_SIO 12'h005
`define MMS_VEC_TMR 12'h007
// data memory
`define MMS_RAM_DEPTH 224
`define MMS_RAM_TOP 8'hDF
`define MMS_WREG_LO 8'h00
`define MMS_WREG_HI 8'h18
`define MMS_STACK_BASE 8'h08
// saved status bits and the spare high address bit in the odd byte
`define MMS_STWORD_SAVE 8'hD0
`define MMS_ODD_A12 5
// reset values
`define MMS_RST_SP 3'h0
`define MMS_RST_STWORD 8'h00
`define MMS_RST_PC 12'h000
`endif

/* include/mms_pkg.sv */
// types shared by the memory map and stack unit
package mms_pkg;
   typedef enum logic [3:0] {
      MMS_OP_NOP = 4'b0000,
      MMS_OP_NEXT = 4'b0001,
      MMS_OP_JMP = 4'b0010,
      MMS_OP_JCOND = 4'b0011,
      MMS_OP_CALL = 4'b0100,
      MMS_OP_EXIT = 4'b0101,
      MMS_OP_EXITS = 4'b0110,
      MMS_OP_INT = 4'b0111,
      MMS_OP_PBANK = 4'b1000,
      MMS_OP_WBANK = 4'b1001,
      MMS_OP_RDREG = 4'b1010,
      MMS_OP_WRREG = 4'b1011,
      MMS_OP_RDIND = 4'b1100,
      MMS_OP_WRIND = 4'b1101,
      MMS_OP_DECJMP = 4'b1110
   } mms_op_e;
   typedef enum logic [1:0] {
      MMS_IRQ_EXT = 2'b00,
      MMS_IRQ_SIO = 2'b01,
      MMS_IRQ_TMR = 2'b10
   } mms_irq_e;
   typedef struct packed {
      mms_op_e op;
      logic [11:0] target;
      logic [2:0] idx;
      logic [7:0] data;
      mms_irq_e irq;
      logic cond;
      logic sel;
   } mms_cmd_s;
   typedef struct packed {
      logic [11:0] pc;
      logic [7:0] ramData;
      logic taken;
      logic [7:0] statusWord;
      logic [2:0] sp;
      logic bankSel;
      logic workBank;
   } mms_rsp_s;
endpackage

/* hw/mms_core.sv */
// program counter, banks, data ram, working registers and return stack
`timescale 1ns/1ps
`include "mms_regs.svh"
module mms_core
   import mms_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // instruction sequencer
   input wire mms_cmd_s cmd,
   output mms_rsp_s rsp
);
   logic [7:0] ram_ff [0:`MMS_RAM_DEPTH-1];
   logic [11:0] pc_ff;
   logic [2:0] sp_ff;
   logic [7:0] statusWord_ff;
   logic bankSel_ff;
   logic workBank_ff;
   logic [7:0] ramAddr_ff;
   logic [7:0] rdData_ff;
   logic taken_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // ram byte at an address; bytes past the top read as zero
   function automatic logic [7:0] ramRd(input logic [7:0] a);
      ramRd = (a <= `MMS_RAM_TOP) ? ram_ff[a] : 8'h00;
   endfunction

   // register operand to ram address for the active working bank
   function automatic logic [7:0] regAddr(input logic [2:0] i,
                                          input logic hi);
      regAddr = (hi ? `MMS_WREG_HI : `MMS_WREG_LO) + {5'h00, i};
   endfunction

   // ram address of the even byte of a stack level
   function automatic logic [7:0] stackAddr(input logic [2:0] s);
      stackAddr = `MMS_STACK_BASE + {4'h0, s, 1'b0};
   endfunction

   // decoded addresses used by the sequencer path
   logic [7:0] dirAddr;
   logic [7:0] ptrAddr;
   logic [7:0] indAddr;
   logic [7:0] djAddr;
   logic [7:0] djVal;
   logic [2:0] popSp;
   logic [7:0] popLo;
   logic [7:0] popHi;
   logic [7:0] pushHi;
   logic [11:0] vecAddr;
   logic [11:0] farTarget;
   logic seqWr;
   logic [7:0] seqWrAddr;
   logic [7:0] seqWrData;
   logic isPush;
   logic apbAcc;
   logic apbWr;

   assign dirAddr = regAddr(cmd.idx, workBank_ff);
   // pointer select is only the low bit: two pointers per bank
   assign ptrAddr = regAddr({2'b00, cmd.sel}, workBank_ff);
   assign indAddr = ramRd(ptrAddr);
   assign djAddr = cmd.target[7:0];
   assign djVal = ramRd(djAddr) - 8'h01;
   assign popSp = sp_ff - 3'h1;
   assign popLo = ramRd(stackAddr(popSp));
   assign popHi = ramRd(stackAddr(popSp) + 8'h01);
   // odd byte: status bits 7, 6, 4; spare address bit 12 is zero here
   assign pushHi = (statusWord_ff & `MMS_STWORD_SAVE) |
                   {4'h0, pc_ff[11:8]};
   // jumps and calls take the bank bit from the selected bank
   assign farTarget = {bankSel_ff, cmd.target[10:0]};
   assign isPush = (cmd.op == MMS_OP_CALL) || (cmd.op == MMS_OP_INT);
   assign apbAcc = psel && penable && pready_ff;
   assign apbWr = apbAcc && pwrite;

   // interrupt vector table
   always_comb
   begin
      case (cmd.irq)
         MMS_IRQ_EXT: vecAddr = `MMS_VEC_EXT;
         MMS_IRQ_SIO: vecAddr = `MMS_VEC_SIO;
         MMS_IRQ_TMR: vecAddr = `MMS_VEC_TMR;
         default: vecAddr = `MMS_VEC_EXT;
      endcase
   end

   // single sequencer ram write port (pushes use a second lane)
   always_comb
   begin
      seqWr = 1'b0;
      seqWrAddr = 8'h00;
      seqWrData = cmd.data;
      case (cmd.op)
         MMS_OP_WRREG:
         begin
            seqWr = 1'b1;
            seqWrAddr = dirAddr;
         end
         MMS_OP_WRIND:
         begin
            seqWr = 1'b1;
            seqWrAddr = indAddr;
         end
         MMS_OP_DECJMP:
         begin
            seqWr = 1'b1;
            seqWrAddr = djAddr;
            seqWrData = djVal;
         end
         default: seqWr = 1'b0;
      endcase
   end

   // data ram; the sequencer wins over software on the same cycle
   always_ff @(posedge clk)
   begin
      if (isPush)
      begin
         ram_ff[stackAddr(sp_ff)] <= pc_ff[7:0];
         ram_ff[stackAddr(sp_ff) + 8'h01] <= pushHi;
      end
      else if (seqWr && (seqWrAddr <= `MMS_RAM_TOP))
         ram_ff[seqWrAddr] <= seqWrData;
      else if (apbWr && (paddr == `MMS_OFF_RDATA) &&
               (ramAddr_ff <= `MMS_RAM_TOP))
         ram_ff[ramAddr_ff] <= pwdata[7:0];
   end

   // program counter; calls push the current counter value itself as the return address
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pc_ff <= `MMS_RST_PC;
      else
         case (cmd.op)
            MMS_OP_NEXT:
               // wraps at the top of the 3k space
               pc_ff <= (pc_ff == `MMS_ROM_TOP) ? `MMS_VEC_RESET :
                        pc_ff + 12'h001;
            MMS_OP_JMP: pc_ff <= farTarget;
            MMS_OP_CALL: pc_ff <= farTarget;
            MMS_OP_JCOND:
               if (cmd.cond)
                  pc_ff <= {pc_ff[11:8], cmd.target[7:0]};
            MMS_OP_DECJMP:
               if (djVal != 8'h00)
                  pc_ff <= {pc_ff[11:8], cmd.target[7:0]};
            MMS_OP_INT: pc_ff <= vecAddr;
            MMS_OP_EXIT, MMS_OP_EXITS:
               pc_ff <= {popHi[3:0], popLo};
            default: pc_ff <= pc_ff;
         endcase
   end

   // stack pointer, wraps both ways through the 3-bit width
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sp_ff <= `MMS_RST_SP;
      else if (isPush)
         sp_ff <= sp_ff + 3'h1;
      else if ((cmd.op == MMS_OP_EXIT) || (cmd.op == MMS_OP_EXITS))
         sp_ff <= popSp;
   end

   // status word: software writes, status return restores bits 7, 6, 4
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         statusWord_ff <= `MMS_RST_STWORD;
      else if (cmd.op == MMS_OP_EXITS)
         statusWord_ff <= (statusWord_ff & ~`MMS_STWORD_SAVE) |
                          (popHi & `MMS_STWORD_SAVE);
      else if (apbWr && (paddr == `MMS_OFF_STWORD))
         statusWord_ff <= pwdata[7:0];
   end

   // bank selects; a select instruction beats a software write
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bankSel_ff <= 1'b0;
         workBank_ff <= 1'b0;
      end
      else if (cmd.op == MMS_OP_PBANK)
         bankSel_ff <= cmd.sel;
      else if (cmd.op == MMS_OP_WBANK)
         workBank_ff <= cmd.sel;
      else if (apbWr && (paddr == `MMS_OFF_CTRL))
      begin
         bankSel_ff <= pwdata[`MMS_CTRL_MB];
         workBank_ff <= pwdata[`MMS_CTRL_RB];
      end
   end

   // read data and loop result back to the sequencer
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdData_ff <= 8'h00;
         taken_ff <= 1'b0;
      end
      else
      begin
         taken_ff <= (cmd.op == MMS_OP_DECJMP) && (djVal != 8'h00);
         case (cmd.op)
            MMS_OP_RDREG: rdData_ff <= ramRd(dirAddr);
            MMS_OP_RDIND: rdData_ff <= ramRd(indAddr);
            MMS_OP_DECJMP: rdData_ff <= djVal;
            default: rdData_ff <= rdData_ff;
         endcase
      end
   end

   // software ram window address
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ramAddr_ff <= 8'h00;
      else if (apbWr && (paddr == `MMS_OFF_RADDR))
         ramAddr_ff <= pwdata[7:0];
   end

   // apb: ready rises in the access cycle, so every transfer is one wait-free
   // access; read data is captured in setup, so a same-cycle change is missed
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else
      begin
         pready_ff <= psel && !penable;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         if (psel && !penable)
            case (paddr)
               `MMS_OFF_CTRL:
                  prdata_ff <= {30'h0, workBank_ff, bankSel_ff};
               `MMS_OFF_STATUS:
               begin
                  prdata_ff[2:0] <= sp_ff;
                  prdata_ff[`MMS_STAT_MB] <= bankSel_ff;
                  prdata_ff[`MMS_STAT_RB] <= workBank_ff;
               end
               `MMS_OFF_PC: prdata_ff <= {20'h0, pc_ff};
               `MMS_OFF_STWORD: prdata_ff <= {24'h0, statusWord_ff};
               `MMS_OFF_RADDR: prdata_ff <= {24'h0, ramAddr_ff};
               `MMS_OFF_RDATA: prdata_ff <= {24'h0, ramRd(ramAddr_ff)};
               default: pslverr_ff <= 1'b1;
            endcase
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign rsp.pc = pc_ff;
   assign rsp.ramData = rdData_ff;
   assign rsp.taken = taken_ff;
   assign rsp.statusWord = statusWord_ff;
   assign rsp.sp = sp_ff;
   assign rsp.bankSel = bankSel_ff;
   assign rsp.workBank = workBank_ff;
endmodule

/* dv/mms_seq_model.sv */
// sequencer stand-in that issues one command per call
`timescale 1ns/1ps
module mms_seq_model
   import mms_pkg::*;
(
   // clock
   input wire logic clk,
   // command to the core
   output mms_cmd_s cmd
);
   // all-zero is the idle command, so the core sits still between calls
   initial cmd = '0;
   // drive just after an edge, hold one cycle, then fall back to idle
   task issue(input mms_cmd_s c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= '0;
      #1;
   endtask
endmodule

/* dv/mms_core_asserts.sv */
// concurrent checks on the memory map and stack unit ports
`timescale 1ns/1ps
module mms_core_asserts
   import mms_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // sequencer
   input wire mms_cmd_s cmd,
   input wire mms_rsp_s rsp
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // vectors, stack steps and branch targets
   a_vec_ext: assert property (cmd.op == MMS_OP_INT &&
      cmd.irq == MMS_IRQ_EXT |=> rsp.pc == 12'h003)
      else $error("external vector wrong");
   a_vec_sio: assert property (cmd.op == MMS_OP_INT &&
      cmd.irq == MMS_IRQ_SIO |=> rsp.pc == 12'h005)
      else $error("serial vector wrong");
   a_vec_tmr: assert property (cmd.op == MMS_OP_INT &&
      cmd.irq == MMS_IRQ_TMR |=> rsp.pc == 12'h007)
      else $error("timer vector wrong");
   a_push_step: assert property (cmd.op inside {MMS_OP_CALL,
      MMS_OP_INT} |=> rsp.sp == $past(rsp.sp) + 3'h1)
      else $error("stack pointer not stepped up");
   a_pop_step: assert property (cmd.op inside {MMS_OP_EXIT,
      MMS_OP_EXITS} |=> rsp.sp == $past(rsp.sp) - 3'h1)
      else $error("stack pointer not stepped down");
   // an apb write in the same cycle could legally change the status word
   a_plain_exit: assert property (cmd.op == MMS_OP_EXIT &&
      !(psel && penable && pwrite) |=> $stable(rsp.statusWord))
      else $error("plain return touched status");
   a_cond_page: assert property (cmd.op == MMS_OP_JCOND && cmd.cond
      |=> rsp.pc == {$past(rsp.pc[11:8]), $past(cmd.target[7:0])})
      else $error("conditional branch left page");
   a_call_any: assert property (cmd.op == MMS_OP_CALL
      |=> rsp.pc == {$past(rsp.bankSel), $past(cmd.target[10:0])})
      else $error("call target wrong");
   a_next_wrap: assert property (cmd.op == MMS_OP_NEXT &&
      rsp.pc == 12'hBFF |=> rsp.pc == 12'h000)
      else $error("counter did not wrap at top");
   a_loop_taken: assert property (cmd.op == MMS_OP_DECJMP
      |=> rsp.taken == (rsp.ramData != 8'h00))
      else $error("loop branch flag wrong");
   // main scenarios reached
   c_int: cover property (cmd.op == MMS_OP_INT);
   c_taken: cover property (rsp.taken);
   c_slverr: cover property (pready && pslverr);
endmodule
bind mms_core mms_core_asserts i_chk (.clk(clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cmd(cmd), .rsp(rsp));

/* dv/mms_core_test.sv */
// self-checking bench for the memory map and stack unit
`timescale 1ns/1ps
`include "mms_regs.svh"
module mms_core_test
   import mms_pkg::*;
;
   typedef struct packed {
      mms_op_e op;
      mms_irq_e irq;
      logic [11:0] tgt;
      logic cond;
      logic [11:0] pc;
      logic [2:0] sp;
   } mms_row_s;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, errSeen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   mms_cmd_s cmd;
   mms_rsp_s rsp;
   int errorCnt = 0;
   int checksDone = 0;
   int cycles = 0;
   mms_row_s rows[8] = '{
      '{MMS_OP_JMP, MMS_IRQ_EXT, 12'h123, 1'b0, 12'h123, 3'h0},
      '{MMS_OP_INT, MMS_IRQ_EXT, 12'h000, 1'b0, 12'h003, 3'h1},
      '{MMS_OP_EXITS, MMS_IRQ_EXT, 12'h000, 1'b0, 12'h123, 3'h0},
      '{MMS_OP_INT, MMS_IRQ_SIO, 12'h000, 1'b0, 12'h005, 3'h1},
      '{MMS_OP_EXIT, MMS_IRQ_EXT, 12'h000, 1'b0, 12'h123, 3'h0},
      '{MMS_OP_INT, MMS_IRQ_TMR, 12'h000, 1'b0, 12'h007, 3'h1},
      '{MMS_OP_JCOND, MMS_IRQ_EXT, 12'h045, 1'b1, 12'h045, 3'h1},
      '{MMS_OP_EXIT, MMS_IRQ_EXT, 12'h000, 1'b0, 12'h123, 3'h0}};
   mms_core i_dut (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd(cmd), .rsp(rsp));
   mms_seq_model i_seq (.clk(clk), .cmd(cmd));
   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // hang guard, far above the roughly 120 cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errorCnt++;
         completeRun();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; waits for pready however long it takes
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task ramRd(input logic [7:0] a);
      apb(1'b1, `MMS_OFF_RADDR, {24'h0, a});
      apb(1'b0, `MMS_OFF_RDATA, 32'h0);
   endtask
   // register operand index rides in the low target bits
   task go(input mms_op_e o, input logic [11:0] t, input logic [7:0] d,
      input logic s, input mms_irq_e q);
      mms_cmd_s c;
      c = '0;
      c.op = o;
      c.target = t;
      c.idx = t[2:0];
      c.data = d;
      c.cond = s;
      c.sel = s;
      c.irq = q;
      i_seq.issue(c);
   endtask
   task completeRun;
      $display("checks %0d errors %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // main sequence
   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk(32'(rsp.pc), 32'h0);
      chk(32'(rsp.sp), 32'h0);
      foreach (rows[k])
      begin
         go(rows[k].op, rows[k].tgt, 8'h00, rows[k].cond, rows[k].irq);
         chk(32'(rsp.pc), 32'(rows[k].pc));
         chk(32'(rsp.sp), 32'(rows[k].sp));
      end
      // saved layout, then plain and status returns
      apb(1'b1, `MMS_OFF_STWORD, 32'hF0);
      go(MMS_OP_CALL, 12'h456, 8'h00, 1'b0, MMS_IRQ_EXT);
      go(MMS_OP_CALL, 12'h789, 8'h00, 1'b0, MMS_IRQ_EXT);
      ramRd(8'h08);
      chk(rd, 32'h23);
      ramRd(8'h09);
      chk(rd, 32'hD1);
      apb(1'b1, `MMS_OFF_STWORD, 32'h00);
      go(MMS_OP_EXIT, 12'h000, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.pc), 32'h456);
      chk(32'(rsp.statusWord), 32'h00);
      go(MMS_OP_EXITS, 12'h000, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.statusWord), 32'hD0);
      // underflow, overflow, deepest entry overwritten
      go(MMS_OP_EXIT, 12'h000, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.sp), 32'h7);
      go(MMS_OP_CALL, 12'h0AB, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.sp), 32'h0);
      go(MMS_OP_CALL, 12'h0CD, 8'h00, 1'b0, MMS_IRQ_EXT);
      ramRd(8'h08);
      chk(rd, 32'hAB);
      // upper program bank, counter wrap at the top of memory
      go(MMS_OP_PBANK, 12'h000, 8'h00, 1'b1, MMS_IRQ_EXT);
      chk({31'h0, rsp.bankSel}, 32'h1);
      go(MMS_OP_JMP, 12'h3FF, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.pc), 32'hBFF);
      apb(1'b0, `MMS_OFF_STATUS, 32'h0);
      chk(rd, 32'h11);
      go(MMS_OP_NEXT, 12'h000, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.pc), 32'h000);
      // working banks and pointer access
      go(MMS_OP_WBANK, 12'h000, 8'h00, 1'b1, MMS_IRQ_EXT);
      chk({31'h0, rsp.workBank}, 32'h1);
      go(MMS_OP_WRREG, 12'h002, 8'h5A, 1'b0, MMS_IRQ_EXT);
      ramRd(8'h1A);
      chk(rd, 32'h5A);
      go(MMS_OP_WBANK, 12'h000, 8'h00, 1'b0, MMS_IRQ_EXT);
      go(MMS_OP_WRREG, 12'h000, 8'hC0, 1'b0, MMS_IRQ_EXT);
      go(MMS_OP_WRIND, 12'h000, 8'h77, 1'b0, MMS_IRQ_EXT);
      ramRd(8'hC0);
      chk(rd, 32'h77);
      go(MMS_OP_RDREG, 12'h000, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.ramData), 32'hC0);
      // indirect read back through the first pointer
      go(MMS_OP_RDIND, 12'h000, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk(32'(rsp.ramData), 32'h77);
      // loop counter far from the register banks
      apb(1'b1, `MMS_OFF_RADDR, 32'h90);
      apb(1'b1, `MMS_OFF_RDATA, 32'h2);
      go(MMS_OP_DECJMP, 12'h090, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk({31'h0, rsp.taken}, 32'h1);
      go(MMS_OP_DECJMP, 12'h090, 8'h00, 1'b0, MMS_IRQ_EXT);
      chk({31'h0, rsp.taken}, 32'h0);
      // unmapped register and ram beyond the top
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, errSeen}, 32'h1);
      ramRd(8'hE0);
      chk(rd, 32'h0);
      // reset in mid-run must clear a non-zero stack pointer again
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk(32'(rsp.pc), 32'h0);
      chk(32'(rsp.sp), 32'h0);
      completeRun();
   end
endmodule
